// file: rtl/rth_io.sv
// trigger, busy, judgement and gate logic with wishbone registers
// Notes on behaviour
// - busy while reading or applying settings
// - judgement from result, polarity selectable
// - gate strobe marks judgement sampling window
// - gate delay, time, period set independently
// - single trigger rise starts one reading
// - triggers ignored while reading, busy held
// - continuous trigger repeats readings while high
// - judgement and gate only in run mode
// - single failure retries configured count
// - all outputs low after reset
//
// Local design decisions: the register addresses and the Wishbone register port.
module rth_io
  import rth_pkg::*;
#(
  parameter int TRIG_MIN_CYCLES = TRIG_MIN_CYC  // trigger width, cycles
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // trigger pins from host
  input  wire logic        single_shot_trigger_i,
  input  wire logic        continuous_trigger_i,
  // handshake pins to host
  output logic             run_o,
  output logic             busy_o,
  output logic             judgement_out_o,
  output logic             gate_o,
  // image reading engine
  output logic             read_start_o,
  input  wire logic        read_done_i,
  input  wire logic        read_ok_i,
  // interrupt
  output logic             irq_o
);
  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  rth_state_t       state;       // sequencer state
  logic [1:0]       mode;        // operating mode
  logic             pol_fail;    // judgement asserts on failure
  logic [TMR_W-1:0] gdelay;      // gate-on delay
  logic [TMR_W-1:0] gtime;       // gate-on time
  logic [TMR_W-1:0] period;      // output period
  logic [7:0]       retry;       // retries after a failure
  logic [7:0]       retry_left;  // retries still allowed
  logic             cont_seq;    // sequence began from continuous
  logic             res_ok;      // last reading result
  logic [4:0]       settle_cnt;  // settings apply time left
  logic [IRQ_W-1:0] irq_stat;    // sticky events
  logic [IRQ_W-1:0] irq_mask;    // event enables
  logic [IRQ_W-1:0] irq_set;     // events this cycle
  logic             sgl_rise;    // qualified single trigger edge
  logic             cont_rise;   // qualified continuous trigger edge
  logic             cont_lvl;    // qualified continuous level
  logic             gtmr_done;   // gate timer ran out
  logic             gtmr_load;   // gate timer load
  logic [TMR_W-1:0] gtmr_val;    // gate timer load value
  logic             ptmr_done;   // period timer ran out
  logic             ptmr_load;   // period timer load
  logic             mode_read;   // mode allows readings
  logic             accept;      // a trigger may start a reading
  logic             again;       // continuous sequence goes on
  logic             wb_req;      // bus request awaiting answer
  logic             wb_wr;       // write takes effect this edge
  logic             cfg_wr;      // a setting is being written
  logic             seq_end;     // sequence finishes this cycle
  // ---------------------------------------------------------------
  // trigger inputs
  // ---------------------------------------------------------------
  // pins synchronised and width qualified
  rth_trig_qual #(.MIN_CYC(TRIG_MIN_CYCLES), .CNT_W(16)) u_sgl_qual (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .pin_i   (single_shot_trigger_i),
    .rise_o  (sgl_rise),
    .level_o ()
  );
  // continuous trigger qualified the same way
  rth_trig_qual #(.MIN_CYC(TRIG_MIN_CYCLES), .CNT_W(16)) u_cont_qual (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .pin_i   (continuous_trigger_i),
    .rise_o  (cont_rise),
    .level_o (cont_lvl)
  );
  // ---------------------------------------------------------------
  // timers
  // ---------------------------------------------------------------
  // gate timer serves delay then on-time
  rth_timer #(.W(TMR_W)) u_gate_tmr (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .load_i  (gtmr_load),
    .value_i (gtmr_val),
    .done_o  (gtmr_done)
  );
  // period timer spaces successive outputs
  rth_timer #(.W(TMR_W)) u_period_tmr (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .load_i  (ptmr_load),
    .value_i (period),
    .done_o  (ptmr_done)
  );
  // ---------------------------------------------------------------
  // sequencer control terms
  // ---------------------------------------------------------------
  assign mode_read = (mode == MODE_RUN) || (mode == MODE_MON);
  // triggers count only when idle and settled
  assign accept    = (state == ST_IDLE) && (settle_cnt == '0) && mode_read;
  // continuous repeats while level stays high
  assign again     = cont_seq && cont_lvl && mode_read;
  // timer loads and the end of a sequence
  always_comb begin
    ptmr_load = 1'b0;
    gtmr_load = 1'b0;
    gtmr_val  = gtime;
    seq_end   = 1'b0;
    unique case (state)
      ST_JUDGE: begin
        // next output waits out the period
        if (ptmr_done) begin
          ptmr_load = 1'b1;
          gtmr_load = 1'b1;
          gtmr_val  = gdelay;
        end
      end
      ST_DELAY: begin
        gtmr_load = gtmr_done;
        gtmr_val  = (gtime == '0) ? gtime : gtime - 1'b1;  // rise cycle counts
      end
      ST_GATE: begin
        seq_end = gtmr_done;
      end
      ST_READ: begin
        // monitor mode finishes with no output
        seq_end = read_done_i && (mode != MODE_RUN) &&
                  (read_ok_i || cont_seq || retry_left == '0);
      end
      default: seq_end = 1'b0;
    endcase
  end
  // ---------------------------------------------------------------
  // reading sequencer
  // ---------------------------------------------------------------
  // one reading per edge, retries, then gated output
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state        <= ST_IDLE;
      read_start_o <= 1'b0;
      retry_left   <= '0;
      cont_seq     <= 1'b0;
      res_ok       <= 1'b0;
    end else begin
      read_start_o <= 1'b0;
      unique case (state)
        ST_IDLE: begin
          if (accept && sgl_rise) begin
            // one reading per edge, plus retries after a failure
            state        <= ST_READ;
            read_start_o <= 1'b1;
            retry_left   <= retry;
            cont_seq     <= 1'b0;
          end else if (accept && cont_lvl) begin
            // continuous reading has no retries
            state        <= ST_READ;
            read_start_o <= 1'b1;
            retry_left   <= '0;
            cont_seq     <= 1'b1;
          end
        end
        ST_READ: begin
          if (read_done_i) begin
            res_ok <= read_ok_i;
            if (!read_ok_i && !cont_seq && retry_left != '0) begin
              // failed single read tries again
              read_start_o <= 1'b1;
              retry_left   <= retry_left - 1'b1;
            end else if (mode == MODE_RUN) begin
              state <= ST_JUDGE;
            end else if (again) begin
              read_start_o <= 1'b1;
            end else begin
              state <= ST_IDLE;
            end
          end
        end
        ST_JUDGE: begin
          // judgement updated, then the gate delay
          if (ptmr_done) begin
            state <= ST_DELAY;
          end
        end
        ST_DELAY: begin
          if (gtmr_done) begin
            state <= ST_GATE;
          end
        end
        ST_GATE: begin
          // busy released after the gate
          if (gtmr_done) begin
            if (again) begin
              state        <= ST_READ;
              read_start_o <= 1'b1;
            end else begin
              state <= ST_IDLE;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
  // ---------------------------------------------------------------
  // host handshake outputs
  // ---------------------------------------------------------------
  // judgement and gate move only in run mode
  always_ff @(posedge clk_i) begin
    if (rst_i || mode != MODE_RUN) begin
      judgement_out_o <= 1'b0;
      gate_o          <= 1'b0;
    end else begin
      if (state == ST_JUDGE && ptmr_done) begin
        // polarity picks ok or fail as active
        judgement_out_o <= res_ok ^ pol_fail;
      end
      if (state == ST_DELAY && gtmr_done) begin
        gate_o <= 1'b1;
      end else if (state == ST_GATE && gtmr_done) begin
        gate_o <= 1'b0;
      end
    end
  end
  // run indicator and busy
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_o  <= 1'b0;
      busy_o <= 1'b0;
    end else begin
      run_o  <= (mode == MODE_RUN);
      busy_o <= (state != ST_IDLE && !(seq_end && !again)) || (settle_cnt != '0) ||
                (accept && (sgl_rise || cont_lvl)) || cfg_wr;
    end
  end
  // ---------------------------------------------------------------
  // settings apply time
  // ---------------------------------------------------------------
  // a settings write holds busy for a while
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      settle_cnt <= '0;
    end else if (cfg_wr) begin
      settle_cnt <= 5'(SETTLE_CYC);
    end else if (settle_cnt != '0) begin
      settle_cnt <= settle_cnt - 1'b1;
    end
  end
  // ---------------------------------------------------------------
  // wishbone slave
  // ---------------------------------------------------------------
  assign wb_req = wb_cyc_i && wb_stb_i;
  assign wb_wr  = wb_req && wb_we_i && wb_ack_o;
  assign cfg_wr = wb_wr && (wb_adr_i == REG_CTRL || wb_adr_i == REG_GDELAY ||
                  wb_adr_i == REG_GTIME || wb_adr_i == REG_PERIOD || wb_adr_i == REG_RETRY);
  // one wait state, ack dropped after one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req && !wb_ack_o;
    end
  end
  // read data captured with the ack, zero if unmapped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= '0;
    end else if (wb_req && !wb_ack_o) begin
      unique case (wb_adr_i)
        REG_CTRL:     wb_dat_o <= {29'h0, pol_fail, mode};
        REG_GDELAY:   wb_dat_o <= {16'h0, gdelay};
        REG_GTIME:    wb_dat_o <= {16'h0, gtime};
        REG_PERIOD:   wb_dat_o <= {16'h0, period};
        REG_RETRY:    wb_dat_o <= {24'h0, retry};
        REG_STATUS:   wb_dat_o <= {26'h0, cont_lvl, res_ok, gate_o,
                                   judgement_out_o, run_o, busy_o};
        REG_IRQ_STAT: wb_dat_o <= {28'h0, irq_stat};
        REG_IRQ_MASK: wb_dat_o <= {28'h0, irq_mask};
        default:      wb_dat_o <= '0;
      endcase
    end
  end
  // settings registers, byte lanes honoured
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode     <= RST_CTRL[CTRL_MODE_LSB +: 2];
      pol_fail <= RST_CTRL[CTRL_POL_BIT];
      gdelay   <= RST_GDELAY;
      gtime    <= RST_GTIME;
      period   <= RST_PERIOD;
      retry    <= RST_RETRY;
      irq_mask <= '0;
    end else if (wb_wr) begin
      for (int b = 0; b < 2; b++) begin
        if (wb_sel_i[b]) begin
          if (wb_adr_i == REG_GDELAY) gdelay[8*b +: 8] <= wb_dat_i[8*b +: 8];
          if (wb_adr_i == REG_GTIME)  gtime[8*b +: 8]  <= wb_dat_i[8*b +: 8];
          if (wb_adr_i == REG_PERIOD) period[8*b +: 8] <= wb_dat_i[8*b +: 8];
        end
      end
      if (wb_sel_i[0] && wb_adr_i == REG_CTRL) begin
        mode     <= wb_dat_i[CTRL_MODE_LSB +: 2];
        pol_fail <= wb_dat_i[CTRL_POL_BIT];
      end
      if (wb_sel_i[0] && wb_adr_i == REG_RETRY) retry <= wb_dat_i[7:0];
      if (wb_sel_i[0] && wb_adr_i == REG_IRQ_MASK) irq_mask <= wb_dat_i[IRQ_W-1:0];
    end
  end
  // ---------------------------------------------------------------
  // interrupts
  // ---------------------------------------------------------------
  // sequence results and refused triggers
  always_comb begin
    irq_set           = '0;
    irq_set[IRQ_DONE] = seq_end;
    irq_set[IRQ_OK]   = seq_end && res_ok && state != ST_READ ||
                        seq_end && state == ST_READ && read_ok_i;
    irq_set[IRQ_FAIL] = seq_end && !res_ok && state != ST_READ ||
                        seq_end && state == ST_READ && !read_ok_i;
    irq_set[IRQ_IGN]  = (sgl_rise || cont_rise) && !accept;
  end
  // sticky bits, write one to clear, set wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat <= '0;
    end else if (wb_wr && wb_sel_i[0] && wb_adr_i == REG_IRQ_STAT) begin
      irq_stat <= (irq_stat & ~wb_dat_i[IRQ_W-1:0]) | irq_set;
    end else begin
      irq_stat <= irq_stat | irq_set;
    end
  end
  // level interrupt from unmasked bits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_stat & irq_mask);
    end
  end
endmodule : rth_io

// file: rtl/rth_pkg.sv
// shared constants for the reader trigger and handshake block
package rth_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;     // 10 mhz system clock
  localparam int TRIG_MIN_NS   = 500000;  // least trigger high time, 0.5 ms
  // least time rounds up to whole cycles
  localparam int TRIG_MIN_CYC  = (TRIG_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_CYC    = 16;      // busy time after a settings write
  localparam int TMR_W         = 16;      // width of timing settings

  // ---------------------------------------------------------------
  // register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_CTRL     = 8'h00;  // mode and polarity
  localparam logic [7:0] REG_GDELAY   = 8'h04;  // gate-on delay, cycles
  localparam logic [7:0] REG_GTIME    = 8'h08;  // gate-on time, cycles
  localparam logic [7:0] REG_PERIOD   = 8'h0c;  // output period, cycles
  localparam logic [7:0] REG_RETRY    = 8'h10;  // retry count
  localparam logic [7:0] REG_STATUS   = 8'h14;  // live state, read only
  localparam logic [7:0] REG_IRQ_STAT = 8'h18;  // sticky events, w1c
  localparam logic [7:0] REG_IRQ_MASK = 8'h1c;  // interrupt enables

  // ---------------------------------------------------------------
  // field positions and codes
  // ---------------------------------------------------------------
  localparam int CTRL_MODE_LSB = 0;  // two-bit operating mode
  localparam int CTRL_POL_BIT  = 2;  // 1: judgement asserts on failure
  localparam logic [1:0] MODE_SET = 2'h0;  // settings, no reading
  localparam logic [1:0] MODE_MON = 2'h1;  // monitor, no judgement or gate
  localparam logic [1:0] MODE_RUN = 2'h2;  // run, full outputs
  localparam int IRQ_W    = 4;
  localparam int IRQ_DONE = 0;  // a reading sequence finished
  localparam int IRQ_OK   = 1;  // sequence ended in a good read
  localparam int IRQ_FAIL = 2;  // sequence ended in a failed read
  localparam int IRQ_IGN  = 3;  // trigger arrived while not accepted

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0]       RST_CTRL   = 8'h00;
  localparam logic [TMR_W-1:0] RST_GDELAY = 16'h0064;
  localparam logic [TMR_W-1:0] RST_GTIME  = 16'h03e8;
  localparam logic [TMR_W-1:0] RST_PERIOD = 16'h07d0;
  localparam logic [7:0]       RST_RETRY  = 8'h00;

  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_READ,
    ST_JUDGE,
    ST_DELAY,
    ST_GATE
  } rth_state_t;

endpackage : rth_pkg

// file: rtl/rth_timer.sv
// loadable down counter used for gate and period timing
module rth_timer
  import rth_pkg::*;
#(
  parameter int W = TMR_W  // counter width
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // control
  input  wire logic         load_i,   // load value this cycle
  input  wire logic [W-1:0] value_i,  // cycles to count
  // status
  output logic              done_o    // count has run out
);

  // ---------------------------------------------------------------
  // counter
  // ---------------------------------------------------------------
  logic [W-1:0] count;  // cycles left

  // load wins, otherwise count down to zero and hold
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count <= '0;
    end else if (load_i) begin
      count <= value_i;
    end else if (count != '0) begin
      count <= count - 1'b1;
    end
  end

  assign done_o = (count == '0);

endmodule : rth_timer

// file: rtl/rth_trig_qual.sv
// trigger pin synchroniser with minimum-width qualification
module rth_trig_qual
  import rth_pkg::*;
#(
  parameter int MIN_CYC = TRIG_MIN_CYC,  // cycles high before accepted
  parameter int CNT_W   = 16             // width of the width counter
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // pin side
  input  wire logic pin_i,
  // qualified side
  output logic      rise_o,   // one pulse per qualified high
  output logic      level_o   // high while qualified
);

  // ---------------------------------------------------------------
  // two-stage synchroniser
  // ---------------------------------------------------------------
  logic             meta;  // first stage, read only by sync
  logic             sync;  // second stage
  logic [CNT_W-1:0] cnt;   // cycles seen high, saturating

  // pin crosses into the clock domain
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta <= 1'b0;
      sync <= 1'b0;
    end else begin
      meta <= pin_i;
      sync <= meta;
    end
  end

  // ---------------------------------------------------------------
  // width qualification
  // ---------------------------------------------------------------
  // count while high, drop to zero on any low
  always_ff @(posedge clk_i) begin
    if (rst_i || !sync) begin
      cnt <= '0;
    end else if (cnt != CNT_W'(MIN_CYC)) begin
      cnt <= cnt + 1'b1;
    end
  end

  // pulse once when the count reaches the minimum
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rise_o <= 1'b0;
    end else begin
      rise_o <= sync && (cnt == CNT_W'(MIN_CYC - 1));
    end
  end

  assign level_o = (cnt == CNT_W'(MIN_CYC));

endmodule : rth_trig_qual

// file: test/rth_engine_model.sv
// image reading engine model answering each start after a latency
module rth_engine_model #(
  parameter int LAT = 6  // cycles from start to result
) (
  // clock
  input  wire logic clk_i,
  // start and wanted result
  input  wire logic start_i,
  input  wire logic ok_i,
  // answer
  output logic      done_o,
  output logic      ok_o
);
  int cnt = 0;  // cycles left in the reading
  initial begin
    done_o = 1'b0;
    ok_o   = 1'b0;
  end
  // ---------------------------------------------
  // one answer per start, result toggles otherwise
  // ---------------------------------------------
  always @(posedge clk_i) begin
    done_o <= 1'b0;
    ok_o   <= ~ok_o;  // not valid outside done
    if (start_i) cnt <= LAT;
    else if (cnt == 1) begin
      cnt    <= 0;
      done_o <= 1'b1;
      ok_o   <= ok_i;
    end else if (cnt > 0) cnt <= cnt - 1;
  end
endmodule : rth_engine_model

// file: test/rth_io_properties.sv
// concurrent checks on the trigger and handshake block ports
module rth_io_properties (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bus and pins
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic run_o,
  input wire logic busy_o,
  input wire logic judgement_out_o,
  input wire logic gate_o,
  input wire logic read_start_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ---------------------------------------------
  // bus handshake and handshake pins
  // ---------------------------------------------
  ack_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  out_reset_a: assert property ($fell(rst_i) |->
    !(run_o || busy_o || judgement_out_o || gate_o || read_start_o))
    else $error("output high after reset");
  gate_busy_a: assert property (gate_o |-> busy_o)
    else $error("gate without busy");
  gate_run_a: assert property (gate_o |-> run_o)
    else $error("gate outside run");
  judge_run_a: assert property (judgement_out_o |-> run_o || $past(run_o))
    else $error("judgement outside run");
  start_busy_a: assert property (read_start_o |-> busy_o)
    else $error("start without busy");
  start_once_a: assert property (read_start_o |=> !read_start_o [*2])
    else $error("start repeated");
endmodule : rth_io_properties

bind rth_io rth_io_properties i_rth_io_properties (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_ack_o, .run_o, .busy_o, .judgement_out_o, .gate_o, .read_start_o);

// file: test/rth_io_tb.sv
// self-checking bench for the trigger and handshake block
module rth_io_tb import rth_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int QC = 8;  // shortened trigger width
  logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, ts = 0, tc = 0, ok = 1;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wd = 32'h0, rd, q;
  logic ack, run, busy, judge, gate, start, done, rok, irq;
  int n_errors = 0, compares = 0, starts = 0, gcnt = 0;
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_errors++; \
  $display("[ERR] %0t mismatch %0h vs %0h", $time, a, b); end end

  always #50 clk = ~clk;
  // count start pulses and gate cycles
  always @(posedge clk) begin
    if (start === 1'b1) starts++;
    if (gate === 1'b1) gcnt++;
  end

  rth_io #(.TRIG_MIN_CYCLES(QC)) i_rth_io (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wd),
    .wb_dat_o(rd), .wb_ack_o(ack), .single_shot_trigger_i(ts), .continuous_trigger_i(tc),
    .run_o(run), .busy_o(busy), .judgement_out_o(judge), .gate_o(gate),
    .read_start_o(start), .read_done_i(done), .read_ok_i(rok), .irq_o(irq));
  rth_engine_model i_rth_engine_model (.clk_i(clk), .start_i(start), .ok_i(ok),
    .done_o(done), .ok_o(rok));

  // ---------------------------------------------
  // bus, pin and wait helpers
  // ---------------------------------------------
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1; stb <= 1; we <= w; adr <= a; wd <= d;
    do begin @(posedge clk); n++; end while (ack !== 1'b1 && n < 20);
    `CHK(ack, 1'b1)
    q = rd;
    cyc <= 0; stb <= 0; we <= 0;
    @(posedge clk);
  endtask : wb
  task automatic idle;
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 500) begin @(posedge clk); n++; end
    `CHK(n < 500, 1'b1)
  endtask : idle
  task automatic cfg(input logic [7:0] a, input logic [31:0] d);
    wb(1, a, d);
    idle;  // no trigger while settling
  endtask : cfg
  task automatic pin(input bit c, input int len);
    if (c) tc <= 1; else ts <= 1;  // held whole cycles
    repeat (len) @(posedge clk);
    tc <= 0; ts <= 0;
    @(posedge clk);
  endtask : pin
  task automatic shot(input logic r, input int len, input int s, input logic j, input int g);
    starts = 0; gcnt = 0; ok <= r;
    pin(0, len);
    idle;
    `CHK(starts, s)
    `CHK(judge, j)
    `CHK(gcnt, g)
  endtask : shot

  // ---------------------------------------------
  // scenarios
  // ---------------------------------------------
  task automatic t_reset;
    logic [7:0]  ra[6] = '{REG_CTRL, REG_GDELAY, REG_GTIME, REG_PERIOD, REG_RETRY, 8'h20};
    logic [31:0] rv[6] = '{32'(RST_CTRL), 32'(RST_GDELAY), 32'(RST_GTIME),
                           32'(RST_PERIOD), 32'(RST_RETRY), 32'h0};
    `CHK({run, busy, judge, gate, irq}, 5'h00)
    for (int i = 0; i < 6; i++) begin
      wb(0, ra[i], 32'h0);
      `CHK(q, rv[i])
    end
    $display("test reset done");
  endtask : t_reset
  task automatic t_single;
    wb(1, REG_CTRL, 32'(MODE_RUN));
    `CHK(busy, 1'b1)
    idle;
    `CHK(run, 1'b1)
    cfg(REG_GDELAY, 32'h2);
    cfg(REG_GTIME, 32'h3);
    cfg(REG_PERIOD, 32'h6);  // above delay plus time
    shot(1, 14, 1, 1'b1, 3);
    wb(0, REG_STATUS, 32'h0);
    `CHK(q, 32'h16)
    shot(1, 4, 0, 1'b1, 0);  // too short to qualify
    $display("test single done");
  endtask : t_single
  task automatic t_retry;
    cfg(REG_RETRY, 32'h2);
    cfg(REG_CTRL, 32'(MODE_RUN) | 32'h4);  // assert on failure
    shot(0, 14, 3, 1'b1, 3);
    $display("test retry done");
  endtask : t_retry
  task automatic t_ignore;
    wb(1, REG_IRQ_STAT, 32'hf);
    wb(1, REG_IRQ_MASK, 32'h0);
    starts = 0;
    wb(1, REG_CTRL, 32'(MODE_RUN));
    pin(0, 14);  // lands inside the settle time
    idle;
    `CHK(starts, 0)
    wb(0, REG_IRQ_STAT, 32'h0);
    `CHK(q[IRQ_IGN], 1'b1)
    `CHK(irq, 1'b0)
    wb(1, REG_IRQ_MASK, 32'h8);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b1)
    wb(1, REG_IRQ_STAT, 32'h8);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b0)
    $display("test ignore done");
  endtask : t_ignore
  task automatic t_cont;
    int s1;
    starts = 0; ok <= 1;
    pin(1, 80);
    repeat (5) @(posedge clk);
    idle;
    s1 = starts;
    `CHK(s1 >= 3, 1'b1)
    repeat (40) @(posedge clk);
    `CHK(starts, s1)
    $display("test continuous done");
  endtask : t_cont
  task automatic t_mon;
    cfg(REG_CTRL, 32'(MODE_MON));
    `CHK(run, 1'b0)
    shot(1, 14, 1, 1'b0, 0);
    $display("test monitor done");
  endtask : t_mon

  task automatic report_and_stop;
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop

  // watchdog well beyond the expected run
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    report_and_stop;
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    t_reset;
    t_single;
    t_retry;
    t_ignore;
    t_cont;
    t_mon;
    report_and_stop;
  end
endmodule : rth_io_tb
